/* File: design/uwp_regs.vh */
`ifndef UWP_REGS_VH
`define UWP_REGS_VH
// register byte offsets
`define UWP_OFS_MODE        8'h04
`define UWP_OFS_BAUD        8'h20
`define UWP_OFS_RX_TIMEOUT  8'h24
`define UWP_OFS_TIMEGUARD   8'h28
`define UWP_OFS_CLK_RATIO   8'h40
`define UWP_OFS_IR_FILTER   8'h4C
`define UWP_OFS_MANCHESTER  8'h50
`define UWP_OFS_LIN_MODE    8'h54
`define UWP_OFS_LIN_ID      8'h58
`define UWP_OFS_WP_MODE     8'hE4
`define UWP_OFS_WP_STATUS   8'hE8
`define UWP_OFS_VERSION     8'hFC
// field layout
`define UWP_MODE_LSB        0
`define UWP_MODE_MSB        3
`define UWP_MODE_LIN_MASTER 4'hA
`define UWP_MODE_LIN_SLAVE  4'hB
`define UWP_KEY_LSB         8
`define UWP_KEY_MSB         31
`define UWP_KEY_VALUE       24'h858365
`define UWP_EN_BIT          0
`define UWP_SRC_LSB         8
`define UWP_SRC_MSB         23
`define UWP_VIOL_BIT        0
`define UWP_DLM_BIT         5
`define UWP_ID_LEN_LSB      5
`define UWP_ID_LEN_MSB      6
// reset values
`define UWP_RST_ZERO        32'h00000000
`define UWP_RST_MANCHESTER  32'h30011004
// version value is arbitrary
`define UWP_RST_VERSION     32'h00000101
`endif

/* File: design/uwp_guard_reg.v */
`timescale 1ns/1ps
`include "uwp_regs.vh"
module uwp_guard_reg #(
   parameter [7:0]  OFS   = 8'h00,
   parameter [31:0] RST   = 32'h00000000,
   parameter [31:0] WMASK = 32'hFFFFFFFF
) (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        wr_en,
   input  wire [7:0]  addr,
   input  wire [31:0] wdata,
   input  wire        protect,
   output wire [31:0] value,
   output wire        blocked
);
   reg  [31:0] val_ff;
   wire        hit;
   assign hit     = wr_en & (addr == OFS);
   assign blocked = hit & protect;
   assign value   = val_ff;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         val_ff <= RST;
      end else if (hit && !protect) begin
         val_ff <= wdata & WMASK;
      end
   end
endmodule

/* File: design/uwp_top.v */
`timescale 1ns/1ps
`include "uwp_regs.vh"
// Contract
// - master mode: identifier writable, sent as identifier
// - slave mode: identifier read-only, last received
// - enable bit changes only with correct key
// - correct key: enable follows written bit
// - protection guards seven configuration registers
// - violation flag set since last status read
// - violation source records offending register offset
// - status read returns value then clears all
// - read-only version register at 0xFC
// - guarded registers writable only while unprotected
// - length mode uses identifier bits five, six
module uwp_top #(
   parameter NREG = 7
) (
   input  wire        clk,
   input  wire        rst_b,
   input  wire [7:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [31:0] rdata_ff,
   input  wire        rx_id_valid,
   input  wire [7:0]  rx_id_char,
   output reg  [3:0]  op_mode_ff,
   output reg  [7:0]  tx_id_char_ff,
   output reg  [7:0]  resp_len_ff,
   output reg         protect_on_ff
);
   localparam [7:0] OFS0 = `UWP_OFS_MODE;
   localparam [7:0] OFS1 = `UWP_OFS_BAUD;
   localparam [7:0] OFS2 = `UWP_OFS_RX_TIMEOUT;
   localparam [7:0] OFS3 = `UWP_OFS_TIMEGUARD;
   localparam [7:0] OFS4 = `UWP_OFS_CLK_RATIO;
   localparam [7:0] OFS5 = `UWP_OFS_IR_FILTER;
   localparam [7:0] OFS6 = `UWP_OFS_MANCHESTER;

   wire [31:0] mode_val;
   wire [31:0] baud_val;
   wire [31:0] rto_val;
   wire [31:0] ttg_val;
   wire [31:0] ratio_val;
   wire [31:0] ifr_val;
   wire [31:0] man_val;
   wire [NREG-1:0] blk;

   reg  [31:0] lin_mode_ff;
   reg  [7:0]  lin_id_ff;
   reg  [7:0]  nxt_lin_id;
   reg         viol_ff;
   reg  [15:0] viol_src_ff;
   reg  [31:0] nxt_rdata;
   reg  [15:0] blk_src;
   wire        is_master;
   wire        is_slave;
   wire        key_ok;
   wire        any_blk;
   wire        st_read;
   wire [3:0]  mode_fld;

   assign mode_fld  = mode_val[`UWP_MODE_MSB:`UWP_MODE_LSB];
   assign is_master = (mode_fld == `UWP_MODE_LIN_MASTER);
   assign is_slave  = (mode_fld == `UWP_MODE_LIN_SLAVE);
   assign key_ok    = (wdata[`UWP_KEY_MSB:`UWP_KEY_LSB] == `UWP_KEY_VALUE);
   assign any_blk   = |blk;
   assign st_read   = rd_stb & (addr == `UWP_OFS_WP_STATUS);

   // the guarded set shares one module so each keeps the same gating
   uwp_guard_reg #(.OFS(OFS0), .RST(`UWP_RST_ZERO)) u_mode (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(mode_val),
      .blocked(blk[0]));
   uwp_guard_reg #(.OFS(OFS1), .RST(`UWP_RST_ZERO)) u_baud (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(baud_val),
      .blocked(blk[1]));
   uwp_guard_reg #(.OFS(OFS2), .RST(`UWP_RST_ZERO)) u_rto (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(rto_val),
      .blocked(blk[2]));
   uwp_guard_reg #(.OFS(OFS3), .RST(`UWP_RST_ZERO)) u_ttg (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(ttg_val),
      .blocked(blk[3]));
   uwp_guard_reg #(.OFS(OFS4), .RST(`UWP_RST_ZERO)) u_ratio (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(ratio_val),
      .blocked(blk[4]));
   uwp_guard_reg #(.OFS(OFS5), .RST(`UWP_RST_ZERO)) u_ifr (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(ifr_val),
      .blocked(blk[5]));
   uwp_guard_reg #(.OFS(OFS6), .RST(`UWP_RST_MANCHESTER)) u_man (
      .clk(clk), .rst_b(rst_b), .wr_en(wr_stb), .addr(addr),
      .wdata(wdata), .protect(protect_on_ff), .value(man_val),
      .blocked(blk[6]));

   always @* begin
      blk_src = {8'h00, addr};
   end

   // LIN mode register is not guarded
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lin_mode_ff <= `UWP_RST_ZERO;
      end else if (wr_stb && addr == `UWP_OFS_LIN_MODE) begin
         lin_mode_ff <= wdata;
      end
   end

   always @* begin
      nxt_lin_id = lin_id_ff;
      if (is_slave) begin
         if (rx_id_valid) begin
            nxt_lin_id = rx_id_char;
         end
      end else if (is_master && wr_stb && addr == `UWP_OFS_LIN_ID) begin
         nxt_lin_id = wdata[7:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lin_id_ff <= 8'h00;
      end else begin
         lin_id_ff <= nxt_lin_id;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         protect_on_ff <= 1'b0;
      end else if (wr_stb && addr == `UWP_OFS_WP_MODE && key_ok) begin
         protect_on_ff <= wdata[`UWP_EN_BIT];
      end
   end

   // a violation in the same cycle as the status read survives the clear
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         viol_ff     <= 1'b0;
         viol_src_ff <= 16'h0000;
      end else if (any_blk) begin
         viol_ff     <= 1'b1;
         viol_src_ff <= blk_src;
      end else if (st_read) begin
         viol_ff     <= 1'b0;
         viol_src_ff <= 16'h0000;
      end
   end

   always @* begin
      nxt_rdata = 32'h00000000;
      case (addr)
         OFS0: nxt_rdata = mode_val;
         OFS1: nxt_rdata = baud_val;
         OFS2: nxt_rdata = rto_val;
         OFS3: nxt_rdata = ttg_val;
         OFS4: nxt_rdata = ratio_val;
         OFS5: nxt_rdata = ifr_val;
         OFS6: nxt_rdata = man_val;
         `UWP_OFS_LIN_MODE: nxt_rdata = lin_mode_ff;
         `UWP_OFS_LIN_ID: nxt_rdata = {24'h000000, lin_id_ff};
         // key field always reads zero
         `UWP_OFS_WP_MODE: nxt_rdata = {31'h00000000, protect_on_ff};
         `UWP_OFS_WP_STATUS: nxt_rdata = {8'h00, viol_src_ff, 7'h00,
                                          viol_ff};
         `UWP_OFS_VERSION: nxt_rdata = `UWP_RST_VERSION;
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 32'h00000000;
      end else if (rd_stb) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end

   // length from identifier: bits 6:5 give 2,2,4,8 bytes (LIN 1.x)
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         op_mode_ff    <= 4'h0;
         tx_id_char_ff <= 8'h00;
         resp_len_ff   <= 8'h01;
      end else begin
         op_mode_ff    <= mode_fld;
         tx_id_char_ff <= lin_id_ff;
         if (lin_mode_ff[`UWP_DLM_BIT]) begin
            case (lin_id_ff[`UWP_ID_LEN_MSB:`UWP_ID_LEN_LSB])
               2'b00:   resp_len_ff <= 8'h02;
               2'b01:   resp_len_ff <= 8'h02;
               2'b10:   resp_len_ff <= 8'h04;
               default: resp_len_ff <= 8'h08;
            endcase
         end else begin
            resp_len_ff <= lin_mode_ff[15:8] + 8'h01;
         end
      end
   end
endmodule

/* File: test/uwp_top_props.sv */
`timescale 1ns/1ps
module uwp_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [31:0] rdata_ff,
   input wire logic [3:0]  op_mode_ff,
   input wire logic        protect_on_ff
);
   wire kw = wr_stb && addr == 8'hE4;
   wire ok = wdata[31:8] == 24'h858365;
   wire mw = wr_stb && addr == 8'h04;
   wire sr = rd_stb && addr == 8'hE8;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_bkey; kw && !ok |=> $stable(protect_on_ff); endproperty
   a_bkey: assert property (p_bkey) else $error("enable moved");
   property p_gkey; kw && ok |=> protect_on_ff == $past(wdata[0]); endproperty
   a_gkey: assert property (p_gkey) else $error("enable wrong");
   property p_blk; mw && protect_on_ff |-> ##2 $stable(op_mode_ff); endproperty
   a_blk: assert property (p_blk) else $error("mode changed");
   property p_free;
      mw && !protect_on_ff |-> ##2 op_mode_ff == $past(wdata[3:0], 2);
   endproperty
   a_free: assert property (p_free) else $error("mode not taken");
   // mode lags its register, so both checks look two edges ahead
   property p_src;
      wr_stb && protect_on_ff && addr == 8'h20 ##1 sr |=> rdata_ff == 32'h2001;
   endproperty
   a_src: assert property (p_src) else $error("source wrong");
   property p_flag;
      wr_stb && protect_on_ff && addr == 8'h50 ##1 sr |=> rdata_ff[0];
   endproperty
   a_flag: assert property (p_flag) else $error("flag missing");
   property p_clr; sr ##1 !wr_stb ##1 sr |=> rdata_ff == 32'h0; endproperty
   a_clr: assert property (p_clr) else $error("status kept");
   property p_ver; rd_stb && addr == 8'hFC |=> rdata_ff == 32'h101; endproperty
   a_ver: assert property (p_ver) else $error("version wrong");
   c_viol: cover property (sr ##1 rdata_ff[0]);
   c_key: cover property (kw && ok);
   c_mode: cover property (mw && protect_on_ff);
endmodule
bind uwp_top uwp_chk u_chk (.*);

/* File: test/uwp_top_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module uwp_top_test;
   logic        clk = 0;
   logic        rst_b = 0;
   logic [7:0]  addr = 0;
   logic [31:0] wdata = 0;
   logic        wr_stb = 0;
   logic        rd_stb = 0;
   logic        rx_id_valid = 0;
   logic [7:0]  rx_id_char = 0;
   wire  [31:0] rdata_ff;
   wire  [3:0]  op_mode_ff;
   wire  [7:0]  tx_id_char_ff;
   wire  [7:0]  resp_len_ff;
   wire         protect_on_ff;
   int          failures = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [31:0] seed = 3;
   logic [31:0] exp_v [7];
   logic [7:0]  offs [7] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'h40, 8'h4C, 8'h50};
   always #5 clk = ~clk;
   uwp_top uut (.*);
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_len(input logic [7:0] id);
      case (id[6:5])
         2'b10: return 8'h04;
         2'b11: return 8'h08;
         default: return 8'h02;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1;
      rd_stb <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      wr_stb <= 0;
      rd_stb <= 1;
      @(posedge clk);
      rd_stb <= 0;
      #1 `CHK("rdata", e, rdata_ff)
   endtask
   // three edges cover the longest output lag behind a write
   task idle();
      @(posedge clk);
      wr_stb <= 0;
      rd_stb <= 0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task give_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      logic [31:0] r;
      repeat (16) @(posedge clk);
      rst_b <= 1;
      rd(8'hFC, 32'h00000101);
      rd(8'h50, 32'h30011004);
      rd(8'hE8, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wr(8'hE4, {r[31:8], 8'h01});
      end
      idle();
      `CHK("protect", 1'b0, protect_on_ff)
      wr(8'hE4, 32'h85836501);
      idle();
      `CHK("protect", 1'b1, protect_on_ff)
      rd(8'hE4, 32'h00000001);
      wr(8'hE4, 32'h85836500);
      for (int i = 0; i < 7; i++) begin
         exp_v[i] = xs();
         wr(offs[i], exp_v[i]);
         rd(offs[i], exp_v[i]);
      end
      wr(8'hE4, 32'h85836501);
      for (int i = 0; i < 7; i++) begin
         wr(offs[i], xs() | 32'h1);
         rd(offs[i], exp_v[i]);
         rd(8'hE8, {16'h0, offs[i], 8'h01});
         rd(8'hE8, 32'h0);
      end
      $display("test protect done");
      wr(8'hE4, 32'h85836500);
      wr(8'h04, 32'hA);
      r = xs();
      wr(8'h58, {24'h0, r[7:0]});
      idle();
      `CHK("tx id", r[7:0], tx_id_char_ff)
      rd(8'h58, {24'h0, r[7:0]});
      wr(8'h04, 32'hB);
      wr(8'h58, {24'h0, ~r[7:0]});
      idle();
      rd(8'h58, {24'h0, r[7:0]});
      @(posedge clk);
      rx_id_valid <= 1;
      rx_id_char <= r[15:8];
      @(posedge clk);
      rx_id_valid <= 0;
      rd(8'h58, {24'h0, r[15:8]});
      wr(8'h54, {16'h0, 1'b0, r[22:16], 8'h00});
      idle();
      `CHK("length", {1'b0, r[22:16]} + 8'h1, resp_len_ff)
      wr(8'h54, 32'h00000020);
      idle();
      `CHK("id length", exp_len(r[15:8]), resp_len_ff)
      $display("test lin done");
      give_verdict();
   end
endmodule
